// File: logic/hsrl_defs.vh
// Constants for the serial ROM configuration loader
`ifndef HSRL_DEFS_VH
`define HSRL_DEFS_VH

// Clock of the loader and the serial ROM link
`define HSRL_CLOCK_PERIOD_NS     5
`define HSRL_ROM_CLOCK_PERIOD_NS 1000
`define HSRL_HALF_CYCLES         ((`HSRL_ROM_CLOCK_PERIOD_NS / 2) / `HSRL_CLOCK_PERIOD_NS)

// Read command: start bit 1, opcode 10, word address 00000
`define HSRL_READ_COMMAND        8'hC0
`define HSRL_COMMAND_LAST_BIT    3'h7

// Data stream layout
`define HSRL_WORD_LAST_BIT       4'hF
`define HSRL_WORD_INDEX_GROUPED  2'h0
`define HSRL_WORD_INDEX_VENDOR   2'h1
`define HSRL_WORD_INDEX_PRODUCT  2'h2
`define HSRL_GROUPED_BIT         14

// Strap settle delay after reset release, in cycles
`define HSRL_STRAP_SETTLE        2'h3

// Buffer entry: word index above sixteen data bits
`define HSRL_ENTRY_WIDTH         18

`endif

// File: logic/hsrl_word_buffer.v
// Two-entry word buffer with valid and ready on both sides
`timescale 1ns/1ps
`include "hsrl_defs.vh"

module hsrl_word_buffer (
   input  wire                          clock,
   input  wire                          resetn,
   input  wire                          inValid,
   output wire                          inReady,
   input  wire [`HSRL_ENTRY_WIDTH-1:0]  inData,
   output wire                          outValid,
   input  wire                          outReady,
   output wire [`HSRL_ENTRY_WIDTH-1:0]  outData
);

   reg  [`HSRL_ENTRY_WIDTH-1:0] entry_reg [0:1];
   reg                          wrPtr_reg;
   reg                          rdPtr_reg;
   reg  [1:0]                   count_reg;
   wire                         doPush;
   wire                         doPop;

   // Honest full and empty from the occupancy count
   assign inReady  = (count_reg != 2'h2);
   assign outValid = (count_reg != 2'h0);
   assign outData  = entry_reg[rdPtr_reg];
   assign doPush   = inValid & inReady;
   assign doPop    = outValid & outReady;

   // Storage, no reset needed on the data
   always @(posedge clock) begin
      if (doPush) begin
         entry_reg[wrPtr_reg] <= inData;
      end
   end

   // Pointers and count
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         wrPtr_reg <= 1'b0;
         rdPtr_reg <= 1'b0;
         count_reg <= 2'h0;
      end else begin
         if (doPush) begin
            wrPtr_reg <= ~wrPtr_reg;
         end
         if (doPop) begin
            rdPtr_reg <= ~rdPtr_reg;
         end
         if (doPush && !doPop) begin
            count_reg <= count_reg + 2'h1;
         end else if (doPop && !doPush) begin
            count_reg <= count_reg - 2'h1;
         end
      end
   end

endmodule

// File: logic/hsrl_config_loader.v
// Power-on configuration loader reading three words from a serial ROM
`timescale 1ns/1ps
`include "hsrl_defs.vh"

// Overview of operation
// - One read after reset, only if strap low
// - Strap low: pulldowns on ROM clock, data
// - Strap high: ROM pin pulldowns disabled
// - Drive start 1, opcode 10, address 00000
// - Release data wire after address; ROM drives
// - Capture dummy zero, three words, MSB first
// - Loader makes ROM clock; ROM shifts on rise
// - After third word: pins tristated, pulldowns on
// - Word 0 bit 14 grouped power; word 1 vendor
// - Word at address 00010 is product identifier
// - Select and fast input low: crystal clock
// - Select and crystal input high: fast clock
module hsrl_config_loader #(
   parameter [15:0] DEFAULT_VENDOR_ID  = 16'h0A5A, // Arbitrary value
   parameter [15:0] DEFAULT_PRODUCT_ID = 16'h05A5, // Arbitrary value
   parameter        DEFAULT_GROUPED    = 1'b0
) (
   input  wire        clock,
   input  wire        resetn,
   input  wire        extConfigEnableN,
   input  wire        clockSourceSelect,
   input  wire        fastClockInput,
   input  wire        crystalIn,
   input  wire        serialRomDataIn,
   input  wire        coreLoadReady,
   output reg         serialRomClock,
   output reg         serialRomClockOe,
   output reg         serialRomDataOut,
   output reg         serialRomDataOe,
   output reg         romPulldownEnable,
   output reg         romWordOrganization,
   output reg  [15:0] vendorIdentifier,
   output reg  [15:0] productIdentifier,
   output reg         groupedPower,
   output reg         configValid,
   output reg         useCrystal,
   output reg         useFastClock
);

   ////////////////////////////////////////////////////////////////////////////////
   // Declarations

   localparam [4:0] ST_STRAP = 5'h01;
   localparam [4:0] ST_SEND  = 5'h02;
   localparam [4:0] ST_RECV  = 5'h04;
   localparam [4:0] ST_FLUSH = 5'h08;
   localparam [4:0] ST_DONE  = 5'h10;

   // Last count of a half period, cut to the counter width on purpose
   localparam integer HALF_LAST_INT = `HSRL_HALF_CYCLES - 1;
   localparam [6:0]   HALF_LAST     = HALF_LAST_INT[6:0];

   reg  [4:0]                   state_reg;
   reg  [4:0]                   syncA_reg;
   reg  [4:0]                   syncB_reg;
   reg  [1:0]                   settle_reg;
   reg  [6:0]                   halfCnt_reg;
   reg  [7:0]                   command_reg;
   reg  [2:0]                   cmdCnt_reg;
   reg  [3:0]                   bitCnt_reg;
   reg  [1:0]                   wordIdx_reg;
   reg  [15:0]                  shift_reg;
   reg                          dummyBit_reg;
   reg                          pending_reg;
   reg  [`HSRL_ENTRY_WIDTH-1:0] pendData_reg;
   reg                          groupedShadow_reg;
   reg  [15:0]                  vendorShadow_reg;
   wire                         tick;
   wire                         strapN;
   wire                         selSync;
   wire                         fastSync;
   wire                         crystalSync;
   wire                         dataSync;
   wire                         bufInReady;
   wire                         bufOutValid;
   wire [`HSRL_ENTRY_WIDTH-1:0] bufOutData;
   wire                         drain;

   // Word index held in the top bits of a buffer entry
   function [1:0] entryIndex;
      input [`HSRL_ENTRY_WIDTH-1:0] entry;
      begin
         entryIndex = entry[`HSRL_ENTRY_WIDTH-1:16];
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Input synchronisers, two flops for every pin input

   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         syncA_reg <= 5'h00;
         syncB_reg <= 5'h00;
      end else begin
         syncA_reg <= {serialRomDataIn, crystalIn, fastClockInput,
                       clockSourceSelect, extConfigEnableN};
         syncB_reg <= syncA_reg;
      end
   end

   assign strapN      = syncB_reg[0];
   assign selSync     = syncB_reg[1];
   assign fastSync    = syncB_reg[2];
   assign crystalSync = syncB_reg[3];
   assign dataSync    = syncB_reg[4];

   ////////////////////////////////////////////////////////////////////////////////
   // Half-period divider for the ROM clock

   assign tick = (halfCnt_reg == HALF_LAST);

   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         halfCnt_reg <= 7'h00;
      end else if (tick) begin
         halfCnt_reg <= 7'h00;
      end else begin
         halfCnt_reg <= halfCnt_reg + 7'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read sequencer

   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         state_reg           <= ST_STRAP;
         settle_reg          <= 2'h0;
         command_reg         <= 8'h00;
         cmdCnt_reg          <= 3'h0;
         bitCnt_reg          <= 4'h0;
         wordIdx_reg         <= 2'h0;
         shift_reg           <= 16'h0000;
         dummyBit_reg        <= 1'b0;
         pending_reg         <= 1'b0;
         pendData_reg        <= {`HSRL_ENTRY_WIDTH{1'b0}};
         serialRomClock      <= 1'b0;
         serialRomClockOe    <= 1'b0;
         serialRomDataOut    <= 1'b0;
         serialRomDataOe     <= 1'b0;
         romPulldownEnable   <= 1'b0;
         romWordOrganization <= 1'b0;
         useCrystal          <= 1'b0;
         useFastClock        <= 1'b0;
      end else begin
         // Word handed to the buffer
         if (pending_reg && bufInReady) begin
            pending_reg <= 1'b0;
         end
         case (state_reg)
            ST_STRAP: begin
               if (settle_reg != `HSRL_STRAP_SETTLE) begin
                  settle_reg <= settle_reg + 2'h1;
               end else begin
                  romWordOrganization <= 1'b1;
                  useCrystal   <= ~selSync & ~fastSync;
                  useFastClock <= selSync & crystalSync;
                  romPulldownEnable <= ~strapN;
                  if (!strapN) begin
                     // Start bit, opcode and address, MSB first
                     command_reg      <= `HSRL_READ_COMMAND << 1;
                     serialRomDataOut <= 1'b1;
                     serialRomDataOe  <= 1'b1;
                     serialRomClockOe <= 1'b1;
                     cmdCnt_reg       <= 3'h0;
                     state_reg        <= ST_SEND;
                  end else begin
                     state_reg <= ST_DONE;
                  end
               end
            end
            ST_SEND: begin
               if (tick) begin
                  if (!serialRomClock) begin
                     serialRomClock <= 1'b1;
                  end else begin
                     serialRomClock <= 1'b0;
                     if (cmdCnt_reg == `HSRL_COMMAND_LAST_BIT) begin
                        // ROM drives its dummy bit from the next rise
                        serialRomDataOe  <= 1'b0;
                        serialRomDataOut <= 1'b0;
                        bitCnt_reg       <= 4'h0;
                        state_reg        <= ST_RECV;
                     end else begin
                        serialRomDataOut <= command_reg[7];
                        command_reg      <= command_reg << 1;
                        cmdCnt_reg       <= cmdCnt_reg + 3'h1;
                     end
                  end
               end
            end
            ST_RECV: begin
               if (tick) begin
                  if (!serialRomClock) begin
                     // Hold the clock low while a word waits for room
                     if (!pending_reg) begin
                        serialRomClock <= 1'b1;
                     end
                  end else begin
                     serialRomClock <= 1'b0;
                     if (!dummyBit_reg) begin
                        // First sample is the dummy zero, dropped
                        dummyBit_reg <= 1'b1;
                     end else begin
                        shift_reg  <= {shift_reg[14:0], dataSync};
                        bitCnt_reg <= bitCnt_reg + 4'h1;
                        if (bitCnt_reg == `HSRL_WORD_LAST_BIT) begin
                           pending_reg  <= 1'b1;
                           pendData_reg <= {wordIdx_reg, shift_reg[14:0], dataSync};
                           wordIdx_reg  <= wordIdx_reg + 2'h1;
                           if (wordIdx_reg == `HSRL_WORD_INDEX_PRODUCT) begin
                              // Tristate link, pulldowns stay on
                              serialRomClockOe <= 1'b0;
                              state_reg        <= ST_FLUSH;
                           end
                        end
                     end
                  end
               end
            end
            ST_FLUSH: begin
               if (!pending_reg) begin
                  state_reg <= ST_DONE;
               end
            end
            ST_DONE: begin
               // Terminal; no second read until the next reset
               state_reg <= ST_DONE;
            end
            default: begin
               state_reg <= ST_DONE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Word buffer between the link and the configuration store

   hsrl_word_buffer wordBuffer (
      .clock    (clock),
      .resetn   (resetn),
      .inValid  (pending_reg),
      .inReady  (bufInReady),
      .inData   (pendData_reg),
      .outValid (bufOutValid),
      .outReady (coreLoadReady),
      .outData  (bufOutData)
   );

   assign drain = bufOutValid & coreLoadReady;

   ////////////////////////////////////////////////////////////////////////////////
   // Configuration store, applied only once complete

   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         groupedShadow_reg <= 1'b0;
         vendorShadow_reg  <= 16'h0000;
         vendorIdentifier  <= 16'h0000;
         productIdentifier <= 16'h0000;
         groupedPower      <= 1'b0;
         configValid       <= 1'b0;
      end else if ((state_reg == ST_STRAP) && (settle_reg == `HSRL_STRAP_SETTLE)
                   && strapN) begin
         // Built-in identity when the ROM is not used
         vendorIdentifier  <= DEFAULT_VENDOR_ID;
         productIdentifier <= DEFAULT_PRODUCT_ID;
         groupedPower      <= DEFAULT_GROUPED;
         configValid       <= 1'b1;
      end else if (drain) begin
         case (entryIndex(bufOutData))
            `HSRL_WORD_INDEX_GROUPED: begin
               groupedShadow_reg <= bufOutData[`HSRL_GROUPED_BIT];
            end
            `HSRL_WORD_INDEX_VENDOR: begin
               vendorShadow_reg <= bufOutData[15:0];
            end
            `HSRL_WORD_INDEX_PRODUCT: begin
               // High byte 15..8, low byte 7..0
               productIdentifier <= bufOutData[15:0];
               vendorIdentifier  <= vendorShadow_reg;
               groupedPower      <= groupedShadow_reg;
               configValid       <= 1'b1;
            end
            default: begin
               configValid <= configValid;
            end
         endcase
      end
   end

endmodule

// File: tb/hsrl_config_loader_chk.sv
// Checker of the configuration loader ports
`timescale 1ns/1ps
module hsrl_config_loader_chk (
   input wire        clock,
   input wire        resetn,
   input wire        extConfigEnableN,
   input wire        clockSourceSelect,
   input wire        fastClockInput,
   input wire        crystalIn,
   input wire        serialRomClock,
   input wire        serialRomClockOe,
   input wire        serialRomDataOut,
   input wire        serialRomDataOe,
   input wire        romPulldownEnable,
   input wire        romWordOrganization,
   input wire [15:0] vendorIdentifier,
   input wire [15:0] productIdentifier,
   input wire        groupedPower,
   input wire        configValid,
   input wire        useCrystal,
   input wire        useFastClock
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);
   ////////////////////////////////////////////////////////////////////////////////
   // Link pin relations, clock source choice and held configuration
   chk_strap_quiet: assert property (extConfigEnableN |-> !serialRomClockOe)
      else $error("ROM clock driven with strap high");
   chk_pulldown_on: assert property (configValid && !extConfigEnableN |-> romPulldownEnable)
      else $error("Pulldowns off with strap low");
   chk_pulldown_off: assert property (romPulldownEnable |-> !extConfigEnableN)
      else $error("Pulldowns on with strap high");
   chk_data_setup: assert property ($changed(serialRomDataOut) |-> !serialRomClock)
      else $error("Data changed while ROM clock high");
   chk_release_fall: assert property ($fell(serialRomDataOe) |-> !serialRomClock && serialRomClockOe)
      else $error("Data released at wrong moment");
   chk_clock_high: assert property ($rose(serialRomClock) |-> ##99 serialRomClock ##1 !serialRomClock)
      else $error("ROM clock high phase not 100 cycles");
   chk_tristate_done: assert property (configValid |-> !serialRomClockOe && !serialRomDataOe)
      else $error("Pins driven after load");
   chk_org_high: assert property (serialRomClockOe |-> romWordOrganization)
      else $error("Organization low during read");
   chk_crystal_sel: assert property (useCrystal |-> !clockSourceSelect && !fastClockInput)
      else $error("Crystal chosen with wrong straps");
   chk_fast_sel: assert property (useFastClock |-> clockSourceSelect && crystalIn)
      else $error("Fast clock chosen with wrong straps");
   chk_apply_hold: assert property (configValid |=> configValid && $stable(vendorIdentifier)
      && $stable(productIdentifier) && $stable(groupedPower))
      else $error("Applied configuration changed");
   // Main scenarios
   cov_load: cover property ($rose(configValid) && !extConfigEnableN);
   cov_default: cover property ($rose(configValid) && extConfigEnableN);
   cov_release: cover property ($fell(serialRomDataOe));
endmodule
bind hsrl_config_loader hsrl_config_loader_chk u_chk (.clock(clock), .resetn(resetn),
   .extConfigEnableN(extConfigEnableN), .clockSourceSelect(clockSourceSelect),
   .fastClockInput(fastClockInput), .crystalIn(crystalIn), .serialRomClock(serialRomClock),
   .serialRomClockOe(serialRomClockOe), .serialRomDataOut(serialRomDataOut),
   .serialRomDataOe(serialRomDataOe), .romPulldownEnable(romPulldownEnable),
   .romWordOrganization(romWordOrganization), .vendorIdentifier(vendorIdentifier),
   .productIdentifier(productIdentifier), .groupedPower(groupedPower),
   .configValid(configValid), .useCrystal(useCrystal), .useFastClock(useFastClock));

// File: tb/hsrl_rom_model.sv
// Three-wire serial ROM model with auto-incrementing address
`timescale 1ns/1ps
module hsrl_rom_model (
   input  wire        romClock,
   input  wire        chipSelect,
   input  wire        wireIn,
   input  wire        orgHigh,
   input  wire [47:0] image,
   output reg         romDrive,
   output reg         romOut,
   output reg  [7:0]  cmdSeen,
   output reg  [7:0]  riseCount
);
   reg [5:0]  bitCount;
   reg [47:0] shiftReg;
   // Chip select follows reset; command in, then dummy and words out on rises
   always @(posedge romClock or negedge chipSelect) begin
      if (!chipSelect) begin
         romDrive <= 1'b0;
         romOut <= 1'b0;
         cmdSeen <= 8'h00;
         riseCount <= 8'h00;
         bitCount <= 6'h00;
         shiftReg <= 48'h0;
      end else begin
         riseCount <= riseCount + 8'h01;
         if (bitCount < 6'h08) begin
            cmdSeen <= {cmdSeen[6:0], wireIn};
         end else if (bitCount == 6'h08) begin
            // Only a read of address zero in 64x16 mode is answered
            // Wire taken once the loader has let go, dummy zero first
            if (cmdSeen == 8'hC0 && orgHigh) begin
               romDrive <= 1'b1;
               romOut <= 1'b0;
               shiftReg <= image;
            end
         end else if (bitCount < 6'h39) begin
            // Words follow back to back, address advancing by itself
            romOut <= shiftReg[47];
            shiftReg <= {shiftReg[46:0], 1'b0};
         end else begin
            romDrive <= 1'b0;
         end
         if (bitCount < 6'h3A) bitCount <= bitCount + 6'h01;
      end
   end
endmodule

// File: tb/tb_hub_serial_rom_config_loader.sv
// Testbench of the serial ROM configuration loader
`timescale 1ns/1ps
module tb_hub_serial_rom_config_loader;
   reg         clock, resetn, strapN, sel, fast, xtal, ready, noise;
   reg  [47:0] image;
   wire        romClk, romClkOe, dataOut, dataOe, pull, rom_word_organization, grp, valid, useX, useF;
   wire        romDrive, romOut;
   wire [15:0] vendor_identifier, product_identifier;
   wire [7:0]  cmd, rises;
   integer     fails, tests_run, cyc;
   reg  [7:0]  riseMark;
   // Shared wire: loader, ROM, pulldown, else a changing level
   wire        romWire = dataOe ? dataOut : romDrive ? romOut : pull ? 1'b0 : noise;
   hsrl_config_loader DUT (.clock(clock), .resetn(resetn), .extConfigEnableN(strapN),
      .clockSourceSelect(sel), .fastClockInput(fast), .crystalIn(xtal),
      .serialRomDataIn(romWire), .coreLoadReady(ready), .serialRomClock(romClk),
      .serialRomClockOe(romClkOe), .serialRomDataOut(dataOut), .serialRomDataOe(dataOe),
      .romPulldownEnable(pull), .romWordOrganization(rom_word_organization), .vendorIdentifier(vendor_identifier),
      .productIdentifier(product_identifier), .groupedPower(grp), .configValid(valid), .useCrystal(useX),
      .useFastClock(useF));
   hsrl_rom_model rom (.romClock(romClk), .chipSelect(resetn), .wireIn(romWire), .orgHigh(rom_word_organization),
      .image(image), .romDrive(romDrive), .romOut(romOut), .cmdSeen(cmd), .riseCount(rises));
   ////////////////////////////////////////////////////////////////////////////////
   // Clock, noise and cycle ceiling
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   always @(posedge clock) begin
      noise <= ~noise;
      cyc = cyc + 1;
      if (cyc == 50000) begin
         fails = fails + 1;
         summarize();
      end
   end
   task summarize();
      $display("Checks %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task check(input string name, input logic [15:0] exp, input logic [15:0] got);
      tests_run = tests_run + 1;
      if (got !== exp) begin
         fails = fails + 1;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask
   // Reset with given straps and ROM contents
   task doReset(input logic n, s, f, x, r, input logic [47:0] img);
      @(posedge clock);
      resetn <= 1'b0;
      {strapN, sel, fast, xtal, ready} <= {n, s, f, x, r};
      image <= img;
      repeat (16) @(posedge clock);
      resetn <= 1'b1;
      repeat (8) @(posedge clock);
   endtask
   task waitValid(input integer limit);
      integer i;
      for (i = 0; i < limit && valid !== 1'b1; i = i + 1) @(posedge clock);
      #1;
   endtask
   // Common end-of-read checks
   task checkLoad(input logic [47:0] img);
      check("valid", 16'h1, {15'h0, valid});
      check("cmd", 16'h00C0, {8'h00, cmd});
      check("riseTotal", 16'h0039, {8'h00, rises});
      check("grouped", {15'h0, img[46]}, {15'h0, grp});
      check("vendor", img[31:16], vendor_identifier);
      check("product", img[15:0], product_identifier);
      check("pinsOe", 16'h0, {14'h0, romClkOe, dataOe});
      check("pulldown", 16'h1, {15'h0, pull});
      riseMark = rises;
      repeat (1000) @(posedge clock);
      check("rises", {8'h00, riseMark}, {8'h00, rises});
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Core stalls: buffer fills, ROM clock stops, then the load completes
   task testStalledRead();
      doReset(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 48'h4000_1234_BEEF);
      check("pulldownOn", 16'h1, {15'h0, pull});
      check("org", 16'h1, {15'h0, rom_word_organization});
      check("crystal", 16'h2, {14'h0, useX, useF});
      repeat (14000) @(posedge clock);
      check("stallValid", 16'h0, {15'h0, valid});
      check("stallClock", 16'h0, {15'h0, romClk});
      ready <= 1'b1;
      waitValid(5000);
      checkLoad(48'h4000_1234_BEEF);
      $display("testStalledRead done");
   endtask
   // Free-flowing read with fast-clock straps and grouped power off
   task testFlowRead();
      doReset(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 48'h0000_A55A_0F0F);
      check("fastClock", 16'h1, {14'h0, useX, useF});
      waitValid(15000);
      checkLoad(48'h0000_A55A_0F0F);
      $display("testFlowRead done");
   endtask
   // Strap high: defaults at once, no link activity, pulldowns off
   task testStrapHigh();
      doReset(1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 48'h4000_1111_2222);
      check("defValid", 16'h1, {15'h0, valid});
      check("defVendor", 16'h0A5A, vendor_identifier);
      check("defProduct", 16'h05A5, product_identifier);
      check("pulldownOff", 16'h0, {15'h0, pull});
      check("badStraps", 16'h0, {14'h0, useX, useF});
      repeat (2000) @(posedge clock);
      check("noRead", 16'h0, {8'h00, rises});
      $display("testStrapHigh done");
   endtask
   initial begin
      {resetn, strapN, sel, fast, xtal, ready, noise} = 7'h0;
      image = 48'h0;
      fails = 0;
      tests_run = 0;
      cyc = 0;
      testStalledRead();
      testFlowRead();
      testStrapHigh();
      summarize();
   end
endmodule
